/* File: sdctl_buf2.sv */
// two-entry valid/ready buffer for write data
`timescale 1ns/1ns
module sdctl_buf2 #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_q [2];
  logic         wr_ptr_q;
  logic         rd_ptr_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  // honest full and empty
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage, written by index
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      wr_ptr_q <= wr_ptr_q ^ push;
      rd_ptr_q <= rd_ptr_q ^ pop;
      cnt_q    <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // sdctl_buf2

/* File: sdctl_params.svh */
// constants for the sdram controller host port: fields, codes, resets
`ifndef SDCTL_PARAMS_SVH
`define SDCTL_PARAMS_SVH

// ---------------------------------------------------------------------
// host bus address fields
// ---------------------------------------------------------------------
`define SDC_SUB_HI    29
`define SDC_SUB_LO    28
`define SDC_BANK_BIT  21
`define SDC_ROW_HI    20
`define SDC_ROW_LO    10
`define SDC_COL_HI    9
`define SDC_COL_LO    2
`define SDC_CFG_HI    27

// ---------------------------------------------------------------------
// address phase sub-operation codes
// ---------------------------------------------------------------------
`define SDC_SUB_RW    2'h0
`define SDC_SUB_MRS   2'h1
`define SDC_SUB_PRE   2'h2
`define SDC_SUB_REF   2'h3

// ---------------------------------------------------------------------
// sdram command codes {cs_n, ras_n, cas_n, we_n}
// ---------------------------------------------------------------------
`define SDC_CMD_NOP   4'h7
`define SDC_CMD_READ  4'h5
`define SDC_CMD_WRITE 4'h4
`define SDC_CMD_ACT   4'h3
`define SDC_CMD_PRE   4'h2
`define SDC_CMD_REF   4'h1
`define SDC_CMD_MRS   4'h0

// ---------------------------------------------------------------------
// reset values and timing counts
// ---------------------------------------------------------------------
`define SDC_CFG_RESET 28'h70fa075
`define SDC_RD_SYNC   4'h2
`define SDC_CLK_MHZ   25

`endif

/* File: sdctl_pkg.sv */
// types shared by the sdram controller host port modules
package sdctl_pkg;

  // main controller states
  typedef enum logic [3:0] {
    SDC_IDLE, SDC_PRE, SDC_CFG, SDC_MRS, SDC_REF1, SDC_REF2, SDC_REF_WAIT,
    SDC_ACT, SDC_WR_W, SDC_WR_C, SDC_WR, SDC_RD_W, SDC_RD_CS, SDC_RD_C,
    SDC_RD
  } sdctl_state_e;

  // sdram command pins, active low
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sdctl_cmd_s;

  // latched host address split
  typedef struct packed {
    logic [1:0]  sub;
    logic        rd;
    logic        bank;
    logic [10:0] row;
    logic [7:0]  col;
  } sdctl_addr_s;

  // controller configuration word layout
  typedef struct packed {
    logic [3:0]  ref_wait;
    logic [15:0] ref_cnt;
    logic        spare;
    logic [2:0]  burst;
    logic [1:0]  rcd;
    logic [1:0]  cas;
  } sdctl_cfg_s;

endpackage

/* File: sdctl_refresh.sv */
// refresh interval counter with sticky request
`timescale 1ns/1ns
module sdctl_refresh (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] load_val,
  input  wire logic        clr,
  output logic             req
);
  logic [15:0] count_q;
  logic        req_q;
  logic        expire;

  assign expire = (count_q == 16'h0000);
  assign req    = req_q;

  // reload on clear or expiry, else count down
  always_ff @(posedge clk) begin
    if (rst || clr || expire) begin
      count_q <= rst ? 16'hffff : load_val;
    end else begin
      count_q <= count_q - 16'h0001;
    end
  end

  // expiry sets the request, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q <= 1'b0;
    end else if (expire) begin
      req_q <= 1'b1;
    end else if (clr) begin
      req_q <= 1'b0;
    end
  end
endmodule // sdctl_refresh

/* File: sdctl_sdram_model.sv */
// behavioural pair of x16 sdrams seen as one 32-bit memory
`timescale 1ns/1ns
`include "sdctl_params.svh"
module sdctl_sdram_model
  import sdctl_pkg::*;
(
  input  wire logic        clk,
  input  wire sdctl_cmd_s  sd_cmd,
  input  wire logic [10:0] sd_addr,
  input  wire logic        sd_ba,
  input  wire logic [31:0] sd_dq_o,
  input  wire logic        sd_dq_oe,
  input  wire logic [1:0]  cas_code,
  input  wire logic [2:0]  burst_code,
  output logic      [31:0] sd_dq_i
);
  logic [31:0] mem [int];
  logic [10:0] row_q [2];
  int          wkey = 0;
  int          wn = 99;
  int          rkey = 0;
  int          rt = 99;
  int          idx;

  initial sd_dq_i = 32'h0;

  // activate, write capture and timed read return
  always @(posedge clk) begin
    idx = rt - cas_code;  // latency is code plus one
    if (sd_cmd == `SDC_CMD_ACT) row_q[sd_ba] = sd_addr;
    if (sd_cmd == `SDC_CMD_WRITE) begin
      wkey = {sd_ba, row_q[sd_ba], sd_addr[7:0]};
      wn = 0;
    end
    if (sd_dq_oe === 1'b1 && wn <= burst_code) begin
      mem[wkey + wn] = sd_dq_o;
      wn++;
    end
    if (idx >= 0 && idx <= burst_code && mem.exists(rkey + idx))
      sd_dq_i <= mem[rkey + idx];
    else
      sd_dq_i <= ~sd_dq_i;  // released bus keeps moving
    rt++;
    if (sd_cmd == `SDC_CMD_READ) begin
      rkey = {sd_ba, row_q[sd_ba], sd_addr[7:0]};
      rt = 1;
    end
  end
endmodule // sdctl_sdram_model

/* File: sdctl_top.sv */
// sdram controller: host ddr port, command fsm, sdram side
`timescale 1ns/1ns
// What this block does
// - phase and direction select four host operations
// - bits 29:28 pick access, mode, precharge, refresh
// - precharge also loads the config word
// - mode value from bits 20:10 drives sdram address
// - latch bank, row, column from address phase
// - row with activate, column with bit ten high
// - capture write words on doubled clock, read words on each clk cycle of the data state once the latency timer reaches zero
// - work at twice the host clock rate
// - config cas code is latency minus one
// - config burst code ends each burst
// - config delay counts activate-to-column waits
// - refresh counter expiry issues auto refresh
// - wait refresh period before next command
// - start idle, branch by decoded host command
// - two refresh states set then drop clear
// - write: activate, wait, command, data states
// - read: activate, wait, delay, command, data
// - phase high means data, low means address
// - column command only after row delay
`include "sdctl_params.svh"
module sdctl_top
  import sdctl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        host_clk,
  input  wire logic [31:0] host_ad_i,
  output logic      [31:0] host_ad_o,
  output logic             host_ad_oe,
  input  wire logic        host_phase_select,
  input  wire logic        host_direction_select,
  output logic             host_busy,
  output logic             host_stall,
  output logic             doubled_internal_clock,
  input  wire logic [31:0] sd_dq_i,
  output logic      [31:0] sd_dq_o,
  output logic             sd_dq_oe,
  output sdctl_cmd_s       sd_cmd,
  output logic      [10:0] sd_addr,
  output logic             sd_ba,
  output logic             sd_cke,
  output logic      [3:0]  sd_dqm
);

  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic burst_done(input logic [2:0] cnt,
                                      input logic [2:0] code);
    burst_done = (cnt == code);
  endfunction

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [31:0] ad_s1_q;
  logic [31:0] ad_s2_q;
  logic [31:0] dq_s1_q;
  logic [31:0] dq_s2_q;
  logic        ph_s1_q;
  logic        ph_s2_q;
  logic        dir_s1_q;
  logic        dir_s2_q;
  logic        hclk_s1_q;
  logic        hclk_s2_q;
  logic        hclk_s3_q;

  // two flops on every pin input, three on host_clk
  always_ff @(posedge clk) begin
    ad_s1_q   <= host_ad_i;
    ad_s2_q   <= ad_s1_q;
    dq_s1_q   <= sd_dq_i;
    dq_s2_q   <= dq_s1_q;
    ph_s1_q   <= host_phase_select;
    ph_s2_q   <= ph_s1_q;
    dir_s1_q  <= host_direction_select;
    dir_s2_q  <= dir_s1_q;
    hclk_s1_q <= host_clk;
    hclk_s2_q <= hclk_s1_q;
    hclk_s3_q <= hclk_s2_q;
  end

  // -------------------------------------------------------------------
  // host command decode
  // -------------------------------------------------------------------
  sdctl_state_e state_q;
  sdctl_state_e state_d;
  sdctl_addr_s  addr_q;
  logic [27:0]  cfg_q;
  sdctl_cfg_s   cfg;
  logic [3:0]   timer_q;
  logic [3:0]   timer_d;
  logic [2:0]   wcnt_q;
  logic [2:0]   wcnt_d;
  logic         host_edge;
  logic         op_addr;
  logic         op_data_wr;
  logic         addr_take;
  logic         cfg_take;
  logic [1:0]   sub_in;
  logic         ref_req;
  logic         ref_clr;
  logic         timer_zero;
  logic [3:0]   rd_lat;

  // both host edges give one word each: doubled rate
  assign host_edge  = hclk_s2_q ^ hclk_s3_q;
  assign op_addr    = !ph_s2_q;
  assign op_data_wr = ph_s2_q && dir_s2_q;
  assign sub_in     = ad_s2_q[`SDC_SUB_HI:`SDC_SUB_LO];
  assign addr_take  = (state_q == SDC_IDLE) && host_edge && op_addr;
  assign cfg_take   = (state_q == SDC_CFG) && host_edge && op_data_wr;
  assign cfg        = sdctl_cfg_s'(cfg_q);
  assign timer_zero = (timer_q == 4'h0);
  assign rd_lat     = {2'b00, cfg.cas} + 4'h1 + `SDC_RD_SYNC;

  // -------------------------------------------------------------------
  // write data buffer
  // -------------------------------------------------------------------
  logic        wr_phase;
  logic        buf_in_valid;
  logic        buf_in_ready;
  logic        buf_out_valid;
  logic        buf_out_ready;
  logic [31:0] buf_out_data;
  logic        wr_word;
  logic        rd_word;

  // words taken on each host edge while a write runs
  assign wr_phase      = (state_q == SDC_ACT) || (state_q == SDC_WR_W) ||
                         (state_q == SDC_WR_C) || (state_q == SDC_WR);
  assign buf_in_valid  = wr_phase && host_edge && op_data_wr;
  assign buf_out_ready = (state_q == SDC_WR_C) || (state_q == SDC_WR);
  assign wr_word       = buf_out_ready && buf_out_valid;
  assign rd_word       = (state_q == SDC_RD) && timer_zero;

  sdctl_buf2 #(
    .W (32)
  ) u_wbuf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_data   (ad_s2_q),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (buf_out_ready)
  );

  // -------------------------------------------------------------------
  // refresh counter
  // -------------------------------------------------------------------
  assign ref_clr = (state_q == SDC_REF1);

  sdctl_refresh u_ref (
    .clk      (clk),
    .rst      (rst),
    .load_val (cfg.ref_cnt),
    .clr      (ref_clr),
    .req      (ref_req)
  );

  // -------------------------------------------------------------------
  // state machine
  // -------------------------------------------------------------------
  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      SDC_IDLE: begin
        if (ref_req) begin
          state_d = SDC_REF1;
        end else if (addr_take) begin
          case (sub_in)
            `SDC_SUB_PRE: state_d = SDC_PRE;
            `SDC_SUB_MRS: state_d = SDC_MRS;
            `SDC_SUB_REF: state_d = SDC_REF1;
            default:      state_d = SDC_ACT;
          endcase
        end
      end
      SDC_PRE:      state_d = SDC_CFG;
      SDC_CFG:      if (cfg_take) state_d = SDC_IDLE;
      SDC_MRS:      state_d = SDC_IDLE;
      SDC_REF1:     state_d = SDC_REF2;
      SDC_REF2:     state_d = SDC_REF_WAIT;
      SDC_REF_WAIT: if (timer_zero) state_d = SDC_IDLE;
      SDC_ACT:      state_d = addr_q.rd ? SDC_RD_W : SDC_WR_W;
      SDC_WR_W:     if (timer_zero) state_d = SDC_WR_C;
      SDC_WR_C: begin
        if (buf_out_valid) begin
          state_d = burst_done(wcnt_q, cfg.burst) ? SDC_IDLE : SDC_WR;
        end
      end
      SDC_WR: begin
        if (wr_word && burst_done(wcnt_q, cfg.burst)) begin
          state_d = SDC_IDLE;
        end
      end
      SDC_RD_W:     if (timer_zero) state_d = SDC_RD_CS;
      SDC_RD_CS:    state_d = SDC_RD_C;
      SDC_RD_C:     state_d = SDC_RD;
      SDC_RD: begin
        if (rd_word && burst_done(wcnt_q, cfg.burst)) begin
          state_d = SDC_IDLE;
        end
      end
      default:      state_d = SDC_IDLE;
    endcase
  end

  // wait timer: row delay, refresh period, read latency
  assign timer_d = (state_q == SDC_ACT)  ? {2'b00, cfg.rcd} :
                   (state_q == SDC_REF2) ? cfg.ref_wait :
                   (state_q == SDC_RD_C) ? rd_lat :
                   timer_zero ? timer_q : timer_q - 4'h1;

  // burst word counter
  assign wcnt_d = (state_q == SDC_IDLE) ? 3'h0 :
                  (wr_word || rd_word) ? wcnt_q + 3'h1 : wcnt_q;

  // state, timer, counter
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= SDC_IDLE;
      timer_q <= 4'h0;
      wcnt_q  <= 3'h0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      wcnt_q  <= wcnt_d;
    end
  end

  // address latch and configuration word
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= '0;
      cfg_q  <= `SDC_CFG_RESET;
    end else begin
      if (addr_take) begin
        addr_q.sub  <= sub_in;
        addr_q.rd   <= !dir_s2_q;
        addr_q.bank <= ad_s2_q[`SDC_BANK_BIT];
        addr_q.row  <= ad_s2_q[`SDC_ROW_HI:`SDC_ROW_LO];
        addr_q.col  <= ad_s2_q[`SDC_COL_HI:`SDC_COL_LO];
      end
      if (cfg_take) begin
        cfg_q <= ad_s2_q[`SDC_CFG_HI:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // sdram command and address outputs
  // -------------------------------------------------------------------
  logic [3:0]  cmd_d;
  logic [10:0] addr_d;
  logic [10:0] col_addr;
  logic        col_cmd;

  // column address with auto precharge bit forced high
  assign col_addr = {1'b1, 2'b00, addr_q.col};
  assign col_cmd  = (state_q == SDC_RD_C) ||
                    ((state_q == SDC_WR_C) && buf_out_valid);
  assign cmd_d    = (state_q == SDC_ACT)  ? `SDC_CMD_ACT :
                    (state_q == SDC_RD_C) ? `SDC_CMD_READ :
                    col_cmd               ? `SDC_CMD_WRITE :
                    (state_q == SDC_PRE)  ? `SDC_CMD_PRE :
                    (state_q == SDC_MRS)  ? `SDC_CMD_MRS :
                    (state_q == SDC_REF1) ? `SDC_CMD_REF : `SDC_CMD_NOP;
  assign addr_d   = col_cmd ? col_addr :
                    (state_q == SDC_PRE) ? 11'h400 :     // all banks
                    addr_q.row;

  // registered sdram pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sd_cmd   <= sdctl_cmd_s'(`SDC_CMD_NOP);
      sd_addr  <= 11'h000;
      sd_ba    <= 1'b0;
      sd_cke   <= 1'b1;
      sd_dqm   <= 4'h0;
      sd_dq_o  <= 32'h00000000;
      sd_dq_oe <= 1'b0;
    end else begin
      sd_cmd   <= sdctl_cmd_s'(cmd_d);
      sd_addr  <= addr_d;
      sd_ba    <= addr_q.bank;
      sd_cke   <= 1'b1;
      sd_dqm   <= 4'h0;
      sd_dq_o  <= buf_out_data;
      sd_dq_oe <= wr_word;
    end
  end

  // -------------------------------------------------------------------
  // host side outputs
  // -------------------------------------------------------------------
  // read words go to the host bus, which we own meanwhile
  always_ff @(posedge clk) begin
    if (rst) begin
      host_ad_o              <= 32'h00000000;
      host_ad_oe             <= 1'b0;
      host_busy              <= 1'b0;
      host_stall             <= 1'b0;
      doubled_internal_clock <= 1'b0;
    end else begin
      if (rd_word) begin
        host_ad_o <= dq_s2_q;
      end
      host_ad_oe <= (state_d == SDC_RD_C) || (state_d == SDC_RD) ||
                    rd_word; // keep bus while last word stands
      host_busy  <= (state_d != SDC_IDLE);
      host_stall <= !buf_in_ready;
      doubled_internal_clock <= host_edge;
    end
  end

endmodule // sdctl_top

/* File: sdctl_top_monitor.sv */
// concurrent checks on the sdram controller top ports
`timescale 1ns/1ns
`include "sdctl_params.svh"
module sdctl_top_monitor
  import sdctl_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        host_clk,
  input wire logic [31:0] host_ad_i,
  input wire logic [31:0] host_ad_o,
  input wire logic        host_ad_oe,
  input wire logic        host_phase_select,
  input wire logic        host_direction_select,
  input wire logic        host_busy,
  input wire logic        host_stall,
  input wire logic        doubled_internal_clock,
  input wire logic [31:0] sd_dq_i,
  input wire logic [31:0] sd_dq_o,
  input wire logic        sd_dq_oe,
  input wire sdctl_cmd_s  sd_cmd,
  input wire logic [10:0] sd_addr,
  input wire logic        sd_ba,
  input wire logic        sd_cke,
  input wire logic [3:0]  sd_dqm
);
  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire logic is_act = (sd_cmd == `SDC_CMD_ACT);
  wire logic is_wr  = (sd_cmd == `SDC_CMD_WRITE);
  wire logic is_rd  = (sd_cmd == `SDC_CMD_READ);
  wire logic is_ref = (sd_cmd == `SDC_CMD_REF);
  wire logic is_nop = (sd_cmd == `SDC_CMD_NOP);
  wire logic col    = is_wr | is_rd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_pulse_single: assert property (doubled_internal_clock |=>
    !doubled_internal_clock) else $error("pulse too long");
  a_edge_pulse: assert property ($changed(host_clk) |->
    ##[2:5] doubled_internal_clock) else $error("edge pulse missing");
  a_act_gap: assert property (is_act |=> !col)
    else $error("column command too soon");
  a_act_to_col: assert property (is_act |-> ##[2:60] col)
    else $error("no column command after activate");
  a_col_precharge: assert property (col |->
    sd_addr[10:8] == 3'h4) else $error("column address bits wrong");
  a_oe_exclusive: assert property (!(host_ad_oe && sd_dq_oe))
    else $error("both buses driven");
  a_write_data: assert property (is_wr |-> sd_dq_oe)
    else $error("write without data");
  a_read_owns: assert property (is_rd |-> ##[0:1] host_ad_oe)
    else $error("host bus not driven on read");
  a_ref_quiet: assert property (is_ref |=> is_nop [*8])
    else $error("command inside refresh wait");
  a_cmd_busy: assert property ((is_act || is_ref) |-> host_busy)
    else $error("busy low during command");
  a_cke_dqm: assert property (sd_cke && sd_dqm == 4'h0)
    else $error("cke or dqm wrong");

  c_write: cover property (is_wr);
  c_read: cover property (is_rd);
  c_refresh: cover property (is_ref);
  c_mode: cover property (sd_cmd == `SDC_CMD_MRS);
endmodule // sdctl_top_monitor

bind sdctl_top sdctl_top_monitor u_mon (.clk, .rst, .host_clk, .host_ad_i,
  .host_ad_o, .host_ad_oe, .host_phase_select, .host_direction_select,
  .host_busy, .host_stall, .doubled_internal_clock, .sd_dq_i, .sd_dq_o,
  .sd_dq_oe, .sd_cmd, .sd_addr, .sd_ba, .sd_cke, .sd_dqm);

/* File: testbench.sv */
// self-checking bench: host ddr commands against an sdram model
`timescale 1ns/1ns
`include "sdctl_params.svh"
module testbench;
  import sdctl_pkg::*;
  logic              clk = 0, rst = 1, host_clk = 0, ph = 0, dir = 0;
  logic       [31:0] ad_i = 32'h0, ad_o, dq_i, dq_o;
  logic              ad_oe, busy, stall, dclk, dq_oe, cke, ba;
  logic       [10:0] sa;
  logic        [3:0] dqm;
  sdctl_cmd_s        cmd;
  logic        [1:0] cas = 2'h1;
  logic        [2:0] bl = 3'h7;
  logic              rcd = 1'b0;
  logic       [47:0] log_q [$];
  logic       [31:0] rd_q [$];
  logic       [31:0] rd_last = 32'h0;
  int                cyc = 0, wr_words = 0, error_cnt = 0, checks_done = 0;

  always #20 clk = ~clk;

  sdctl_top dut (.clk(clk), .rst(rst), .host_clk(host_clk),
    .host_ad_i(ad_i), .host_ad_o(ad_o), .host_ad_oe(ad_oe),
    .host_phase_select(ph), .host_direction_select(dir),
    .host_busy(busy), .host_stall(stall), .doubled_internal_clock(dclk),
    .sd_dq_i(dq_i), .sd_dq_o(dq_o), .sd_dq_oe(dq_oe), .sd_cmd(cmd),
    .sd_addr(sa), .sd_ba(ba), .sd_cke(cke), .sd_dqm(dqm));

  sdctl_sdram_model u_mem (.clk(clk), .sd_cmd(cmd), .sd_addr(sa),
    .sd_ba(ba), .sd_dq_o(dq_o), .sd_dq_oe(dq_oe), .cas_code(cas),
    .burst_code(bl), .sd_dq_i(dq_i));

  // ---------------------------------------------------------------
  // observers, timeout and report
  // ---------------------------------------------------------------
  // log commands, count write words, collect read words
  always @(posedge clk) begin
    cyc++;
    if (!rst && cmd !== `SDC_CMD_NOP) log_q.push_back({cyc, cmd, ba, sa});
    if (dq_oe === 1'b1) wr_words++;
    if (ad_oe === 1'b1 && ad_o !== rd_last) rd_q.push_back(ad_o);
    rd_last = ad_o;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // pop the next logged command and compare its code
  task automatic chk_cmd(input string nm, input logic [3:0] c,
                         output logic [47:0] e);
    int n = 0;
    while (log_q.size() == 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    e = (log_q.size() == 0) ? '1 : log_q.pop_front();
    chk_word(nm, {28'h0, c}, {28'h0, e[15:12]});
  endtask

  // one host word: new values, then a host clock edge
  task automatic host_word(input logic p, input logic d,
                           input logic [31:0] v);
    @(posedge clk);
    #1;
    ph = p;
    dir = d;
    ad_i = v;
    host_clk = ~host_clk;
    repeat (7) @(posedge clk);
  endtask

  task automatic wait_idle();
    int n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk_word("busy", 32'h0, {31'h0, busy});
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [31:0] adr(input logic [1:0] sub,
      input logic b, input logic [10:0] r, input logic [7:0] c);
    return {2'h0, sub, 6'h0, b, r, c, 2'h0};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [47:0] e, a;
    logic  [2:0] bls [4];
    logic [31:0] t_ref;
    logic [10:0] row;
    logic  [7:0] cl;
    bls = '{3'h0, 3'h1, 3'h3, 3'h7};
    t_ref = 0;
    repeat (20) @(posedge clk);
    #1 rst = 0;
    @(posedge clk);
    #1;
    chk_word("idle pins", {19'h0, `SDC_CMD_NOP, 9'h100},
      {19'h0, cmd, cke, dqm, busy, ad_oe, dq_oe, stall});
    for (int i = 0; i < 4; i++) begin
      bl = bls[i];
      cas = i[1] ? 2'h2 : 2'h1;
      rcd = i[0];
      row = 11'h3c1 + 11'(i);
      cl = 8'h10 * 8'(i);
      host_word(0, 1, adr(`SDC_SUB_PRE, 0, 0, 0));
      host_word(1, 1, {4'h0, 4'h7, 16'h0800, 1'b0, bl, 1'b0, rcd, cas});
      chk_cmd("precharge", `SDC_CMD_PRE, e);
      chk_word("precharge all", 32'h1, {31'h0, e[10]});
      host_word(0, 1, adr(`SDC_SUB_REF, 0, 0, 0));
      chk_cmd("host refresh", `SDC_CMD_REF, e);
      t_ref = e[47:16];
      wait_idle();
      host_word(0, 1, adr(`SDC_SUB_MRS, 0, 11'h5a0 + 11'(i), 0));
      chk_cmd("mode load", `SDC_CMD_MRS, e);
      chk_word("mode value", 32'h5a0 + i, {21'h0, e[10:0]});
      // write burst, one word per host edge
      host_word(0, 1, adr(`SDC_SUB_RW, i[0], row, cl));
      wr_words = 0;
      for (int k = 0; k <= bl; k++)
        host_word(1, 1, 32'hd0a00000 + 32'(i * 256 + k));
      chk_cmd("write act", `SDC_CMD_ACT, a);
      chk_word("act row", {20'h0, i[0], row}, {20'h0, a[11:0]});
      chk_cmd("write cmd", `SDC_CMD_WRITE, e);
      chk_word("write col", {20'h0, i[0], 3'h4, cl}, {20'h0, e[11:0]});
      chk_word("write gap", 1, {31'h0, e[47:16] - a[47:16] >= rcd + 2});
      wait_idle();
      chk_word("write words", 32'(bl) + 1, wr_words);
      chk_word("write stall", 32'h0, {31'h0, stall});
      // read back the same burst
      rd_q.delete();
      host_word(0, 0, adr(`SDC_SUB_RW, i[0], row, cl));
      host_word(1, 0, ~ad_i);
      chk_cmd("read act", `SDC_CMD_ACT, a);
      chk_cmd("read cmd", `SDC_CMD_READ, e);
      chk_word("read col", {20'h0, i[0], 3'h4, cl}, {20'h0, e[11:0]});
      chk_word("read gap", 32'(rcd) + 3, e[47:16] - a[47:16]);
      wait_idle();
      chk_word("read words", 32'(bl) + 1, rd_q.size());
      for (int k = 0; k <= bl; k++)
        chk_word("read data", 32'hd0a00000 + 32'(i * 256 + k),
          (k < rd_q.size()) ? rd_q[k] : 32'h0);
      chk_word("host bus free", 0, {31'h0, ad_oe});
    end
    // refresh counter expiry after the last host refresh
    chk_cmd("auto refresh", `SDC_CMD_REF, e);
    chk_word("refresh due", 1, {31'h0, (e[47:16] - t_ref >= 2040) &&
      (e[47:16] - t_ref <= 2090)});
    final_report();
  end
endmodule // testbench
